// ---- src/dsp_defs.svh ----
// constants for the dual serial port pin logic
// assumes mclk at 10 MHz, pins sampled through two-flop synchronisers
// Behaviour
// - alert output asserts on any limit exceeded; active level selectable high or low.
// - after reset the alert output is active low until software picks high.
// - alert and spi data output are open-drain; only pull low or release.
// - spi read data shifts out on each falling serial clock edge.
// - spi input data is captured on each rising serial clock edge.
// - i2c address from three-state pin: low 1001000, float 1001010, high 1001011.
// - pin address latched on eighth clock of second matching address transfer.
// - once latched, changes on the address pin are ignored.
// - the one serial clock times all reads and writes in both modes.
// - spi transfers are framed by select low; accept and drive only then.
// - port starts in i2c; once spi is selected it stays until srst.
`ifndef DSP_DEFS_SVH
`define DSP_DEFS_SVH
`define DSP_ADDR_LOW 7'h48
`define DSP_ADDR_FLOAT 7'h4A
`define DSP_ADDR_HIGH 7'h4B
`define DSP_BIT_LAST 4'h7
`define DSP_BIT_ACK 4'h8
`define DSP_SPI_LAST 3'h7
`define DSP_HITS_LATCH 2'h1
`define DSP_TX_IDLE 8'hFF
`define DSP_BYTE_RST 8'h00
`define DSP_ADDR_RST 7'h00
`endif

// ---- src/dsp_pkg.sv ----
// types shared by the dual serial port pin logic
// assumes the defs header supplies all numeric constants
package dsp_pkg;
    // serial pins as seen at the pads, raw and unsynchronised
    typedef struct packed {
        logic sclk;
        logic data_in;
        logic cs_n;
        logic add_high;
        logic add_float;
    } dsp_pins_t;
    // i2c receiver states
    typedef enum logic [1:0] {
        DSP_I2C_IDLE = 2'b00,
        DSP_I2C_ADDR = 2'b01,
        DSP_I2C_DATA = 2'b10,
        DSP_I2C_SKIP = 2'b11
    } dsp_i2c_st_t;
    // received byte toward the core
    typedef struct packed {
        logic [7:0] data;
        logic valid;
    } dsp_rx_t;
endpackage

// ---- src/dsp_port.sv ----
// dual serial port pin logic: spi/i2c shifting, address strap, alert pin
// assumes raw pins asynchronous to mclk; alert condition and tx byte from core logic on mclk
`timescale 1ns/1ps
`include "dsp_defs.svh"
module dsp_port
    import dsp_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // pads
    input wire dsp_pins_t pins,
    output logic sda_o,
    output logic sda_oe,
    output logic dout_o,
    output logic dout_oe,
    output logic int_o,
    output logic int_oe,
    // core side
    input wire logic alert_cond,
    input wire logic pol_wr,
    input wire logic pol_high,
    input wire logic [7:0] tx_byte,
    output dsp_rx_t rx,
    output logic spi_mode,
    output logic addr_latched,
    output logic [6:0] i2c_addr
);
    ////////////////////////////////////////////////////////////////////////////
    // synchronisers and edge detection
    logic [1:0] sclk_s, din_s, csn_s, addh_s, addf_s;
    logic sclk_d, din_d, csn_d;
    always_ff @(posedge mclk) begin
        sclk_s <= {sclk_s[0], pins.sclk};
        din_s <= {din_s[0], pins.data_in};
        csn_s <= {csn_s[0], pins.cs_n};
        addh_s <= {addh_s[0], pins.add_high};
        addf_s <= {addf_s[0], pins.add_float};
        sclk_d <= sclk_s[1];
        din_d <= din_s[1];
        csn_d <= csn_s[1];
    end
    wire sclk_rise = sclk_s[1] & ~sclk_d;
    wire sclk_fall = ~sclk_s[1] & sclk_d;
    wire i2c_start = sclk_s[1] & sclk_d & din_d & ~din_s[1];
    wire i2c_stop = sclk_s[1] & sclk_d & ~din_d & din_s[1];
    wire csn_fall = csn_d & ~csn_s[1];

    ////////////////////////////////////////////////////////////////////////////
    // alert pin, polarity register
    logic pol_high_r;
    always_ff @(posedge mclk) begin
        if (srst) pol_high_r <= 1'b0;
        else if (pol_wr) pol_high_r <= pol_high;
    end
    // open drain: pull low when the pin level must be low
    assign int_o = 1'b0;
    assign int_oe = pol_high_r ? ~alert_cond : alert_cond;

    ////////////////////////////////////////////////////////////////////////////
    // mode lock: first select falling edge locks spi
    logic spi_lock_r;
    always_ff @(posedge mclk) begin
        if (srst) spi_lock_r <= 1'b0;
        else if (csn_fall) spi_lock_r <= 1'b1;
    end
    assign spi_mode = spi_lock_r;
    wire cs_act = spi_lock_r & ~csn_s[1];

    ////////////////////////////////////////////////////////////////////////////
    // spi shifter
    logic [2:0] spi_cnt_r;
    logic [7:0] spi_sh_r, spi_tx_r;
    wire [7:0] spi_sh_nxt = {spi_sh_r[6:0], din_s[1]};
    wire spi_byte_done = cs_act & sclk_rise & (spi_cnt_r == `DSP_SPI_LAST);
    always_ff @(posedge mclk) begin
        if (srst || !cs_act) begin
            spi_cnt_r <= 3'h0;
            spi_tx_r <= `DSP_TX_IDLE;
        end else begin
            if (sclk_rise) begin
                spi_sh_r <= spi_sh_nxt;
                spi_cnt_r <= spi_cnt_r + 3'h1;
            end
            if (sclk_fall)
                spi_tx_r <= (spi_cnt_r == 3'h0) ? tx_byte : {spi_tx_r[6:0], 1'b1};
        end
    end
    assign dout_o = 1'b0;
    assign dout_oe = cs_act & ~spi_tx_r[7];

    ////////////////////////////////////////////////////////////////////////////
    // i2c address selection and latch
    logic addr_lock_r, match_r, ack_r;
    logic [6:0] addr_r;
    logic [1:0] hits_r;
    logic [3:0] i2c_cnt_r;
    logic [7:0] i2c_sh_r;
    dsp_i2c_st_t i2c_st_r;
    wire [6:0] pin_addr = addf_s[1] ? `DSP_ADDR_FLOAT : (addh_s[1] ? `DSP_ADDR_HIGH : `DSP_ADDR_LOW);
    wire [6:0] cur_addr = addr_lock_r ? addr_r : pin_addr;
    wire [7:0] i2c_sh_nxt = {i2c_sh_r[6:0], din_s[1]};
    wire i2c_busy = ~spi_lock_r & ((i2c_st_r == DSP_I2C_ADDR) | (i2c_st_r == DSP_I2C_DATA));
    wire bit8 = i2c_busy & sclk_rise & (i2c_cnt_r == `DSP_BIT_LAST);
    wire bit9 = i2c_busy & sclk_rise & (i2c_cnt_r == `DSP_BIT_ACK);
    wire addr_hit = bit8 & (i2c_st_r == DSP_I2C_ADDR) & (i2c_sh_nxt[7:1] == cur_addr);
    wire do_latch = addr_hit & ~addr_lock_r & (hits_r == `DSP_HITS_LATCH);
    wire ackable = (i2c_st_r == DSP_I2C_DATA) | ((i2c_st_r == DSP_I2C_ADDR) & match_r);
    assign i2c_addr = cur_addr;
    assign addr_latched = addr_lock_r;

    // address hit count and latch
    always_ff @(posedge mclk) begin
        if (srst) begin
            addr_lock_r <= 1'b0;
            addr_r <= `DSP_ADDR_RST;
            hits_r <= 2'h0;
        end else if (addr_hit && !addr_lock_r) begin
            hits_r <= hits_r + 2'h1;
            if (do_latch) begin
                addr_lock_r <= 1'b1;
                addr_r <= pin_addr;
            end
        end
    end

    // i2c byte receiver
    always_ff @(posedge mclk) begin
        if (srst || spi_lock_r || i2c_stop) begin
            i2c_st_r <= DSP_I2C_IDLE;
            i2c_cnt_r <= 4'h0;
            match_r <= 1'b0;
        end else if (i2c_start) begin
            i2c_st_r <= DSP_I2C_ADDR;
            i2c_cnt_r <= 4'h0;
            match_r <= 1'b0;
        end else if (bit9) begin
            i2c_cnt_r <= 4'h0;
            // only the address byte decides between taking and skipping data
            unique case (i2c_st_r)
                DSP_I2C_ADDR: i2c_st_r <= match_r ? DSP_I2C_DATA : DSP_I2C_SKIP;
                DSP_I2C_DATA: i2c_st_r <= DSP_I2C_DATA;
                DSP_I2C_IDLE, DSP_I2C_SKIP: i2c_st_r <= i2c_st_r;
            endcase
        end else if (i2c_busy && sclk_rise) begin
            i2c_sh_r <= i2c_sh_nxt;
            i2c_cnt_r <= i2c_cnt_r + 4'h1;
            if (addr_hit) match_r <= 1'b1;
        end
    end

    // acknowledge pulls data low across the ninth clock
    always_ff @(posedge mclk) begin
        if (srst || spi_lock_r || i2c_st_r == DSP_I2C_IDLE) ack_r <= 1'b0;
        else if (sclk_fall) ack_r <= (i2c_cnt_r == `DSP_BIT_ACK) & ackable;
    end
    assign sda_o = 1'b0;
    assign sda_oe = ack_r;

    ////////////////////////////////////////////////////////////////////////////
    // received byte toward the core
    wire i2c_byte = bit8 & (i2c_st_r == DSP_I2C_DATA);
    always_ff @(posedge mclk) begin
        if (srst) begin
            rx <= '{data: `DSP_BYTE_RST, valid: 1'b0};
        end else begin
            rx.valid <= spi_byte_done | i2c_byte;
            if (spi_byte_done) rx.data <= spi_sh_nxt;
            else if (i2c_byte) rx.data <= i2c_sh_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    a_alert_level: assert property (!pol_high_r && alert_cond |-> int_oe)
        else $error("alert not pulled low while active low");
    a_alert_reset_pol: assert property (@(posedge mclk) disable iff (1'b0) srst |=> !pol_high_r)
        else $error("alert polarity not active low after reset");
    a_dout_frame: assert property (dout_oe |-> cs_act && !dout_o)
        else $error("data output driven outside frame or high");
    a_spi_tx_fall: assert property (cs_act && sclk_fall && spi_cnt_r != 3'h0 && $past(cs_act)
        |=> spi_tx_r[7:1] == $past(spi_tx_r[6:0]))
        else $error("transmit not shifted on falling edge");
    a_spi_rx_rise: assert property (cs_act && sclk_rise |=> spi_sh_r[0] == $past(din_s[1]))
        else $error("input bit not captured on rising edge");
    a_addr_table: assert property (!addr_lock_r && !addf_s[1] && addh_s[1] |-> i2c_addr == `DSP_ADDR_HIGH)
        else $error("address pin high gives wrong address");
    a_addr_latch: assert property ($rose(addr_lock_r) |-> $past(bit8) && $past(hits_r) == `DSP_HITS_LATCH)
        else $error("address latched at wrong moment");
    a_addr_hold: assert property (addr_lock_r |=> addr_lock_r && $stable(addr_r))
        else $error("latched address changed");
    a_sh_on_edge: assert property ($changed(i2c_sh_r) |-> $past(sclk_rise))
        else $error("shift register moved without clock edge");
    a_cs_idle: assert property (!cs_act |=> spi_cnt_r == 3'h0 && !dout_oe)
        else $error("spi active outside select frame");
    a_spi_stay: assert property (spi_lock_r |=> spi_lock_r [*4])
        else $error("spi mode lock dropped");
    // alert level in active-high mode, acknowledge placement, byte strobe
    a_alert_high: assert property (pol_high_r && alert_cond |-> !int_oe)
        else $error("alert not released while active high");
    a_ack_slot: assert property ($rose(sda_oe) |-> $past(i2c_cnt_r) == `DSP_BIT_ACK)
        else $error("acknowledge outside ninth clock");
    a_rx_single: assert property (rx.valid |=> !rx.valid)
        else $error("received byte strobe longer than one cycle");
    // address table for the other pin states, and the refusal paths
    a_addr_float: assert property (!addr_lock_r && addf_s[1] |-> i2c_addr == `DSP_ADDR_FLOAT)
        else $error("floating address pin gives wrong address");
    a_addr_low: assert property (!addr_lock_r && !addf_s[1] && !addh_s[1] |-> i2c_addr == `DSP_ADDR_LOW)
        else $error("address pin low gives wrong address");
    a_skip_quiet: assert property (i2c_st_r == DSP_I2C_SKIP |-> !sda_oe)
        else $error("acknowledge given to another address");
    a_spi_no_ack: assert property (spi_lock_r |=> !sda_oe)
        else $error("i2c acknowledge while spi locked");

    // main scenarios seen at least once
    c_spi_byte: cover property (spi_byte_done);
    c_addr_skip: cover property (i2c_st_r == DSP_I2C_SKIP);
    c_addr_latch: cover property ($rose(addr_lock_r));
    c_ack: cover property ($rose(sda_oe));
    c_alert_high: cover property (pol_high_r && alert_cond);
endmodule

// ---- dv/dsp_host.sv ----
// host model: drives the shared serial clock, data line and select
// assumes the bench resolves open-drain levels with pull-ups
`timescale 1ns/1ps
module dsp_host (
    // clock
    input wire logic mclk,
    // pads
    input wire logic dout,
    output logic scl,
    output logic sdo,
    output logic cs_n
);
    int hp = 4;
    // lines idle high, select released
    initial begin
        scl = 1'b1;
        sdo = 1'b1;
        cs_n = 1'b1;
    end
    task automatic w(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // eight bits then a released acknowledge slot
    task automatic i2c_byte(input logic [7:0] b);
        for (int i = 7; i >= -1; i--) begin
            sdo <= (i < 0) ? 1'b1 : b[i];
            w(hp);
            scl <= 1'b1;
            w(hp);
            scl <= 1'b0;
        end
    endtask
    // start, address with write bit, one data byte, stop
    task automatic i2c_frame(input logic [6:0] a, input logic [7:0] d);
        w(hp);
        sdo <= 1'b0;
        w(hp);
        scl <= 1'b0;
        i2c_byte({a, 1'b0});
        i2c_byte(d);
        sdo <= 1'b0;
        w(hp);
        scl <= 1'b1;
        w(hp);
        sdo <= 1'b1;
        w(hp);
    endtask
    // one framed byte, data set while clock low, read sampled late in high phase
    task automatic spi_byte(input logic [7:0] b, output logic [7:0] got);
        cs_n <= 1'b0;
        w(hp);
        for (int i = 7; i >= 0; i--) begin
            scl <= 1'b0;
            sdo <= b[i];
            w(hp);
            scl <= 1'b1;
            w(hp);
            got[i] = dout;
        end
        cs_n <= 1'b1;
        sdo <= 1'b1;
        w(hp);
    endtask
endmodule

// ---- dv/dsp_port_tb.sv ----
// self-checking bench for the dual serial port pin logic
// assumes pull-ups on data and dout lines, host model drives the pads
`timescale 1ns/1ps
module dsp_port_tb;
    import dsp_pkg::*;
    logic mclk = 1'b0, srst = 1'b1, alert_cond = 1'b0, pol_wr = 1'b0, pol_high = 1'b0;
    logic add_high = 1'b0, add_float = 1'b0;
    logic [7:0] tx_byte = 8'h00, rd, got;
    logic scl, sdo, cs_n, sda_o, sda_oe, dout_o, dout_oe, int_o, int_oe, spi_mode, addr_latched;
    logic [6:0] i2c_addr;
    logic [6:0] tbl [3] = '{7'h48, 7'h4a, 7'h4b};
    dsp_rx_t rx;
    dsp_pins_t pins;
    int fail_count = 0, num_checks = 0, seed = 32'hee83;
    logic [7:0] expq [$];
    int acks = 0;
    logic ack_q = 1'b0;
    // open-drain resolution with pull-ups
    assign pins = '{sclk: scl, data_in: sdo & ~(sda_oe & ~sda_o), cs_n: cs_n,
        add_high: add_high, add_float: add_float};
    dsp_host host (.mclk(mclk), .dout(dout_oe ? dout_o : 1'b1), .scl(scl), .sdo(sdo), .cs_n(cs_n));
    dsp_port uut (.mclk(mclk), .srst(srst), .pins(pins), .sda_o(sda_o), .sda_oe(sda_oe), .dout_o(dout_o),
        .dout_oe(dout_oe), .int_o(int_o), .int_oe(int_oe), .alert_cond(alert_cond), .pol_wr(pol_wr),
        .pol_high(pol_high), .tx_byte(tx_byte), .rx(rx), .spi_mode(spi_mode), .addr_latched(addr_latched),
        .i2c_addr(i2c_addr));
    initial forever #50 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic chk1(input string n, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s exp %b got %b", n, e, g);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // acknowledge pulses the device puts on the data line
    always @(negedge mclk) begin
        ack_q <= sda_oe;
        if (sda_oe === 1'b1 && ack_q === 1'b0) acks <= acks + 1;
    end
    // received bytes against the oldest note, looked at mid-cycle
    always @(negedge mclk) begin
        if (rx.valid === 1'b1) begin
            if (expq.size() == 0) chk1("rx.valid", 1'b0, 1'b1);
            else chk("rx.data", expq.pop_front(), rx.data);
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge mclk);
        srst <= 1'b0;
        alert_cond <= 1'b1;
        repeat (3) @(posedge mclk);
        chk1("spi_mode", 1'b0, spi_mode);
        chk1("int_oe", 1'b1, int_oe);
        chk1("int_o", 1'b0, int_o);
        pol_high <= 1'b1;
        pol_wr <= 1'b1;
        @(posedge mclk);
        pol_wr <= 1'b0;
        repeat (2) @(posedge mclk);
        chk1("int_oe", 1'b0, int_oe);
        alert_cond <= 1'b0;
        repeat (2) @(posedge mclk);
        chk1("int_oe", 1'b1, int_oe);
        // reset in mid-run brings back the active-low default
        srst <= 1'b1;
        repeat (3) @(posedge mclk);
        srst <= 1'b0;
        repeat (2) @(posedge mclk);
        chk1("int_oe", 1'b0, int_oe);
        $display("alert test done");
        for (int k = 0; k < 3; k++) begin
            add_high <= (k == 2);
            add_float <= (k == 1);
            repeat (5) @(posedge mclk);
            chk("i2c_addr", {1'b0, tbl[k]}, {1'b0, i2c_addr});
        end
        host.i2c_frame(7'h48, 8'h5a);
        chk("acks", 8'h00, 8'(acks));
        rd = 8'($random(seed));
        expq.push_back(rd);
        host.i2c_frame(7'h4b, rd);
        chk1("addr_latched", 1'b0, addr_latched);
        chk("acks", 8'h02, 8'(acks));
        rd = 8'($random(seed));
        expq.push_back(rd);
        host.i2c_frame(7'h4b, rd);
        chk1("addr_latched", 1'b1, addr_latched);
        chk("acks", 8'h04, 8'(acks));
        add_high <= 1'b0;
        repeat (5) @(posedge mclk);
        chk("i2c_addr", 8'h4b, {1'b0, i2c_addr});
        $display("i2c test done");
        repeat (2) begin
            tx_byte <= 8'($random(seed));
            rd = 8'($random(seed));
            expq.push_back(rd);
            @(posedge mclk);
            host.spi_byte(rd, got);
            chk("dout", tx_byte, got);
        end
        chk1("spi_mode", 1'b1, spi_mode);
        chk1("dout_oe", 1'b0, dout_oe);
        host.i2c_frame(7'h4b, 8'h33);
        chk("acks", 8'h04, 8'(acks));
        for (int i = 0; i < 200 && expq.size() > 0; i++) @(posedge mclk);
        chk("rx_pending", 8'h00, 8'(expq.size()));
        $display("spi test done");
        end_sim();
    end
endmodule
